// *** irq_nest_pkg.sv ***
// Constants and state type for the three-level nesting interrupt controller
package irq_nest_pkg;

  localparam int unsigned LVL_W = 2;
  localparam int unsigned SRC_W = 2;
  localparam int unsigned MASK_W = 8;
  localparam int unsigned EXT_N = 2;

  // Priority levels, 0 lowest, 2 highest
  localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
  localparam logic [LVL_W-1:0] LVL_MAX = 2'h2;

  // Field positions in the priority selection registers
  localparam int unsigned PRIO_A_EXT0_LSB = 0;
  localparam int unsigned PRIO_A_EXT1_LSB = 2;
  localparam int unsigned PRIO_C_TIMER_LSB = 0;

  // Level mask field: number of masked levels counted from level 0
  localparam int unsigned MASK_LVL_LSB = 0;
  localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;

  // Edge select encoding per pin
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  // Source identifiers shown to the core
  localparam logic [SRC_W-1:0] SRC_NONE = 2'h0;
  localparam logic [SRC_W-1:0] SRC_EXT0 = 2'h1;
  localparam logic [SRC_W-1:0] SRC_EXT1 = 2'h2;
  localparam logic [SRC_W-1:0] SRC_TIMER = 2'h3;

  typedef struct packed {
    logic [EXT_N-1:0] pin_meta;
    logic [EXT_N-1:0] pin_sync;
    logic [EXT_N-1:0] pin_prev;
    logic [EXT_N-1:0] req_flag;
    logic [MASK_W-1:0] level_mask;
    logic irq_req;
    logic [LVL_W-1:0] irq_level;
    logic [SRC_W-1:0] irq_src;
    logic [EXT_N-1:0] port_in;
  } ctl_state_t;

  localparam ctl_state_t STATE_RESET = '{
    pin_meta: 2'h0, pin_sync: 2'h0, pin_prev: 2'h0, req_flag: 2'h0,
    level_mask: MASK_RESET, irq_req: 1'b0, irq_level: 2'h0,
    irq_src: SRC_NONE, port_in: 2'h0};

endpackage

// *** priority_interrupt_nesting.sv ***
// Three-level interrupt priority controller with level mask and pin edge requests
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Every source has a software-chosen priority level of 0, 1 or 2.
// - Level 0 is the lowest and level 2 the highest when requests are compared.
// - An 8-bit readable and writable level mask decides which levels are masked.
// - With level 0 masked, a level-0 timer request is not raised until the mask drops.
// - A request above the mask level is raised even while a handler runs, allowing nesting.
// - A setting picks which edge of external pin 0 raises its request.
// - An external pin 0 request goes to the core only while its enable bit is set.
// - A flag records a pin 0 edge and the handler clears it when servicing starts.
// - Pin 0 takes its level from one priority register and the timer from another.
// - A selection makes pins 0 and 1 interrupt inputs or plain port pins.
module priority_interrupt_nesting
  import irq_nest_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 25 MHz
  input wire logic NRST, // Synchronous reset, active low
  input wire logic [EXT_N-1:0] EXT_PIN, // External interrupt pins 1 and 0
  input wire logic [EXT_N-1:0] PIN_FUNC_SEL, // 1 interrupt input, 0 port pin
  input wire logic [EXT_N-1:0] EXT_EDGE_SEL, // 1 rising, 0 falling
  input wire logic [EXT_N-1:0] EXT_IRQ_ENABLE, // Pin request enables
  input wire logic [EXT_N-1:0] FLAG_CLR, // Pulse clears pin request flag
  input wire logic [7:0] PRIO_SEL_A, // Pin 0 and pin 1 levels
  input wire logic [7:0] PRIO_SEL_C, // Timer level
  input wire logic [7:0] PRIO_SEL_E, // Spare levels, unused sources
  input wire logic TIMER_REQ, // Timer compare request, held by timer
  input wire logic MASK_WE, // Level mask write strobe
  input wire logic [MASK_W-1:0] MASK_WDATA, // Level mask write data
  input wire logic CPU_IDISABLE, // Core interrupt-disable bit
  output logic [MASK_W-1:0] MASK_RDATA, // Level mask readback
  output logic [EXT_N-1:0] EXT_FLAGS, // Pin request flags
  output logic [EXT_N-1:0] PORT_IN, // Synced pin levels in port mode
  output logic IRQ_REQ, // Request to the core
  output logic [LVL_W-1:0] IRQ_LEVEL, // Level of the raised request
  output logic [SRC_W-1:0] IRQ_SRC // Source of the raised request
);

  ctl_state_t r_reg;
  ctl_state_t r_next;

  // Levels above the top level fold onto the top level
  function automatic logic [LVL_W-1:0] clamp_lvl(input logic [LVL_W-1:0] lvl);
    clamp_lvl = (lvl > LVL_MAX) ? LVL_MAX : lvl;
  endfunction

  // Open when the level sits above every masked level
  function automatic logic lvl_open(input logic [LVL_W-1:0] lvl,
                                    input logic [MASK_W-1:0] msk);
    lvl_open = (lvl >= msk[MASK_LVL_LSB +: LVL_W]);
  endfunction

  logic [LVL_W-1:0] lvl_ext0;
  logic [LVL_W-1:0] lvl_ext1;
  logic [LVL_W-1:0] lvl_timer;
  logic [EXT_N-1:0] edge_hit;
  logic pend_ext0;
  logic pend_ext1;

  assign lvl_ext0 = clamp_lvl(PRIO_SEL_A[PRIO_A_EXT0_LSB +: LVL_W]);
  assign lvl_ext1 = clamp_lvl(PRIO_SEL_A[PRIO_A_EXT1_LSB +: LVL_W]);
  assign lvl_timer = clamp_lvl(PRIO_SEL_C[PRIO_C_TIMER_LSB +: LVL_W]);
  assign pend_ext0 = r_reg.req_flag[0] & EXT_IRQ_ENABLE[0];
  assign pend_ext1 = r_reg.req_flag[1] & EXT_IRQ_ENABLE[1];

  always_comb begin
    for (int i = 0; i < EXT_N; i++) begin
      if (EXT_EDGE_SEL[i] == EDGE_RISE) begin
        edge_hit[i] = r_reg.pin_sync[i] & ~r_reg.pin_prev[i];
      end else begin
        edge_hit[i] = ~r_reg.pin_sync[i] & r_reg.pin_prev[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic found;
    logic [LVL_W-1:0] best_lvl;
    logic [SRC_W-1:0] best_src;
    found = 1'b0;
    best_lvl = LVL_LOW;
    best_src = SRC_NONE;
    r_next = r_reg;
    r_next.pin_meta = EXT_PIN;
    r_next.pin_sync = r_reg.pin_meta;
    r_next.pin_prev = r_reg.pin_sync;
    for (int i = 0; i < EXT_N; i++) begin
      if (PIN_FUNC_SEL[i]) begin
        r_next.port_in[i] = 1'b0;
        // Edge set wins over a same-cycle clear
        r_next.req_flag[i] = edge_hit[i] | (r_reg.req_flag[i] & ~FLAG_CLR[i]);
      end else begin
        r_next.port_in[i] = r_reg.pin_sync[i];
        r_next.req_flag[i] = r_reg.req_flag[i] & ~FLAG_CLR[i];
      end
    end
    if (MASK_WE) begin
      r_next.level_mask = MASK_WDATA;
    end
    // Highest open level wins; ties go to pin 0, then pin 1, then timer
    if (pend_ext0 && lvl_open(lvl_ext0, r_reg.level_mask)) begin
      found = 1'b1;
      best_lvl = lvl_ext0;
      best_src = SRC_EXT0;
    end
    if (pend_ext1 && lvl_open(lvl_ext1, r_reg.level_mask) &&
        (!found || lvl_ext1 > best_lvl)) begin
      found = 1'b1;
      best_lvl = lvl_ext1;
      best_src = SRC_EXT1;
    end
    if (TIMER_REQ && lvl_open(lvl_timer, r_reg.level_mask) &&
        (!found || lvl_timer > best_lvl)) begin
      found = 1'b1;
      best_lvl = lvl_timer;
      best_src = SRC_TIMER;
    end
    // Raised whenever open and CPU_IDISABLE is clear, even inside a running handler
    r_next.irq_req = found & ~CPU_IDISABLE;
    r_next.irq_level = best_lvl;
    r_next.irq_src = found ? best_src : SRC_NONE;
    // Pin pipeline keeps tracking in reset, so no false edge follows release
    if (!NRST) begin
      r_next = STATE_RESET;
      r_next.pin_meta = EXT_PIN;
      r_next.pin_sync = r_reg.pin_meta;
      r_next.pin_prev = r_reg.pin_sync;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    r_reg <= r_next;
  end

  assign MASK_RDATA = r_reg.level_mask;
  assign EXT_FLAGS = r_reg.req_flag;
  assign PORT_IN = r_reg.port_in;
  assign IRQ_REQ = r_reg.irq_req;
  assign IRQ_LEVEL = r_reg.irq_level;
  assign IRQ_SRC = r_reg.irq_src;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  sequence pin0_rise_s;
    PIN_FUNC_SEL[0] && EXT_EDGE_SEL[0] && r_reg.pin_sync[0] && !r_reg.pin_prev[0];
  endsequence

  sequence pin0_fall_s;
    PIN_FUNC_SEL[0] && !EXT_EDGE_SEL[0] && !r_reg.pin_sync[0] && r_reg.pin_prev[0];
  endsequence

  edge_sets_flag_a: assert property ((pin0_rise_s or pin0_fall_s) |=> EXT_FLAGS[0])
    else $error("pin 0 edge did not set its flag");

  flag_holds_a: assert property (EXT_FLAGS[0] && !FLAG_CLR[0] |=> EXT_FLAGS[0])
    else $error("pin 0 flag dropped without a clear");

  port_mode_quiet_a: assert property (!PIN_FUNC_SEL[0] && !EXT_FLAGS[0] |=> !EXT_FLAGS[0])
    else $error("pin 0 flag set while in port mode");

  enable_gates_a: assert property (IRQ_REQ && IRQ_SRC == SRC_EXT0 |->
    $past(EXT_IRQ_ENABLE[0]) && $past(EXT_FLAGS[0]))
    else $error("pin 0 raised while disabled or not flagged");

  mask_write_a: assert property (MASK_WE ##1 !MASK_WE |=> MASK_RDATA == $past(MASK_WDATA, 2))
    else $error("level mask did not keep the written value");

  level_above_mask_a: assert property (IRQ_REQ |->
    IRQ_LEVEL >= $past(MASK_RDATA[MASK_LVL_LSB +: LVL_W]))
    else $error("raised request sits at a masked level");

  timer_level_a: assert property (IRQ_REQ && IRQ_SRC == SRC_TIMER |->
    IRQ_LEVEL == $past(clamp_lvl(PRIO_SEL_C[PRIO_C_TIMER_LSB +: LVL_W])))
    else $error("timer level not taken from its priority register");

  nest_raise_a: assert property (TIMER_REQ && !CPU_IDISABLE &&
    lvl_open(lvl_timer, MASK_RDATA) |=> IRQ_REQ && IRQ_LEVEL >= $past(lvl_timer))
    else $error("open timer request was not raised");

  high_wins_a: assert property (TIMER_REQ && pend_ext0 && !pend_ext1 && !CPU_IDISABLE &&
    lvl_timer > lvl_ext0 && lvl_open(lvl_timer, MASK_RDATA) |=> IRQ_SRC == SRC_TIMER)
    else $error("lower level request won arbitration");

  sequence pin0_clear_s;
    FLAG_CLR[0] && !(PIN_FUNC_SEL[0] && edge_hit[0]);
  endsequence

  flag_clear_a: assert property (pin0_clear_s |=> !EXT_FLAGS[0])
    else $error("pin 0 flag survived its clear");

  no_false_edge_a: assert property (!EXT_FLAGS[0] && !edge_hit[0] |=> !EXT_FLAGS[0])
    else $error("pin 0 flag set without a selected edge");

  ext0_level_a: assert property (IRQ_REQ && IRQ_SRC == SRC_EXT0 |->
    IRQ_LEVEL == $past(clamp_lvl(PRIO_SEL_A[PRIO_A_EXT0_LSB +: LVL_W])))
    else $error("pin 0 level not taken from its priority register");

  idisable_blocks_a: assert property (CPU_IDISABLE |=> !IRQ_REQ)
    else $error("request raised while interrupts disabled");

  masked_quiet_a: assert property (TIMER_REQ && !pend_ext0 && !pend_ext1 &&
    !lvl_open(lvl_timer, MASK_RDATA) |=> !IRQ_REQ)
    else $error("masked timer request was raised");

  tie_order_a: assert property (pend_ext0 && !pend_ext1 && !CPU_IDISABLE &&
    lvl_open(lvl_ext0, MASK_RDATA) && lvl_timer <= lvl_ext0 |=> IRQ_SRC == SRC_EXT0)
    else $error("pin 0 lost to a request of no higher level");

  port_in_follow_a: assert property (!PIN_FUNC_SEL[0] |=>
    PORT_IN[0] == $past(r_reg.pin_sync[0]))
    else $error("port level not passed through");

  port_in_quiet_a: assert property (PIN_FUNC_SEL[0] |=> !PORT_IN[0])
    else $error("port level shown while pin is an interrupt input");

  level_cap_a: assert property (IRQ_REQ |-> IRQ_LEVEL <= LVL_MAX)
    else $error("raised level above the top level");

  mask_idle_a: assert property (!MASK_WE |=> $stable(MASK_RDATA))
    else $error("level mask changed without a write");

endmodule

// *** irq_core_model.sv ***
// Core model: takes pin 0 requests, masks level 0, then reopens nesting
module irq_core_model
  import irq_nest_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic svc_en, // Handler enabled
  input wire logic irq_req, // Request from controller
  input wire logic [SRC_W-1:0] irq_src, // Raised source
  output logic flag_clr0, // Pin 0 flag clear pulse
  output logic mask_we, // Mask write pulse, data masks level 0
  output logic idisable // Interrupt-disable bit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    flag_clr0 = 1'b0;
    mask_we = 1'b0;
    idisable = 1'b0;
  end
  always @(posedge clk) begin
    flag_clr0 <= 1'b0;
    mask_we <= 1'b0;
    if (svc_en && irq_req && irq_src === SRC_EXT0 && !idisable) begin
      idisable <= 1'b1;
      flag_clr0 <= 1'b1;
      mask_we <= 1'b1;
    end else if (mask_we) begin
      idisable <= 1'b0;
    end
  end
endmodule

// *** priority_interrupt_nesting_tb_top.sv ***
// Bench for the nesting interrupt controller
module priority_interrupt_nesting_tb_top
  import irq_nest_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic tmr; logic [7:0] prio; logic [7:0] mask; logic idis;
    logic req; logic [1:0] lvl; logic [1:0] src;
  } row_t;
  row_t rows [9] = '{
    '{1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 2'h0, SRC_TIMER},
    '{1'b1, 8'h01, 8'hA5, 1'b0, 1'b1, 2'h1, SRC_TIMER},
    '{1'b1, 8'h00, 8'h01, 1'b0, 1'b0, 2'h0, SRC_NONE},
    '{1'b1, 8'hFE, 8'h02, 1'b0, 1'b1, 2'h2, SRC_TIMER},
    '{1'b1, 8'h01, 8'h5E, 1'b0, 1'b0, 2'h0, SRC_NONE},
    '{1'b1, 8'h03, 8'h02, 1'b0, 1'b1, 2'h2, SRC_TIMER},
    '{1'b1, 8'h02, 8'hFF, 1'b0, 1'b0, 2'h0, SRC_NONE},
    '{1'b1, 8'h02, 8'h00, 1'b1, 1'b0, 2'h2, SRC_TIMER},
    '{1'b0, 8'h02, 8'h00, 1'b0, 1'b0, 2'h0, SRC_NONE}};
  logic clk, nrst, tmr, tb_we, tb_idis, svc, m_clr0, m_we, m_idis, req;
  logic [1:0] pin, fsel, esel, en, tb_clr, flags, port_in, lvl, src;
  logic [7:0] pa, pc, tb_wd, rdata;
  int fails = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  priority_interrupt_nesting DUT (.CLK_SYS(clk), .NRST(nrst), .EXT_PIN(pin),
    .PIN_FUNC_SEL(fsel), .EXT_EDGE_SEL(esel), .EXT_IRQ_ENABLE(en),
    .FLAG_CLR(tb_clr | {1'b0, m_clr0}), .PRIO_SEL_A(pa), .PRIO_SEL_C(pc),
    .PRIO_SEL_E(8'h00), .TIMER_REQ(tmr), .MASK_WE(tb_we | m_we),
    .MASK_WDATA(m_we ? 8'h01 : tb_wd), .CPU_IDISABLE(tb_idis | m_idis),
    .MASK_RDATA(rdata), .EXT_FLAGS(flags), .PORT_IN(port_in), .IRQ_REQ(req),
    .IRQ_LEVEL(lvl), .IRQ_SRC(src));
  irq_core_model CORE (.clk(clk), .svc_en(svc), .irq_req(req), .irq_src(src),
    .flag_clr0(m_clr0), .mask_we(m_we), .idisable(m_idis));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic r, input logic [1:0] l, input logic [1:0] s);
    total_checks++;
    if ({req, lvl, src} !== {r, l, s}) begin
      fails++;
      $display("[FAIL] %0t request %b %h %h", $time, req, lvl, src);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run;
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    {nrst, tmr, tb_we, tb_idis, svc, pin, en, tb_clr, pa, pc, tb_wd} = '0;
    fsel = 2'h3;
    esel = 2'h1;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wait_n(1);
    chk_v(rdata, MASK_RESET);
    chk_irq(1'b0, 2'h0, SRC_NONE);
    foreach (rows[i]) begin
      @(posedge clk);
      tmr <= rows[i].tmr;
      pc <= rows[i].prio;
      tb_idis <= rows[i].idis;
      tb_we <= 1'b1;
      tb_wd <= rows[i].mask;
      @(posedge clk);
      tb_we <= 1'b0;
      wait_n(2);
      chk_v(rdata, rows[i].mask);
      chk_irq(rows[i].req, rows[i].lvl, rows[i].src);
    end
    // Pin 0 at level 2, disabled first
    @(posedge clk);
    pa <= 8'h02;
    pin <= 2'h1;
    wait_n(5);
    chk_v({6'h0, flags}, 8'h01);
    chk_irq(1'b0, 2'h0, SRC_NONE);
    @(posedge clk);
    en <= 2'h1;
    wait_n(2);
    chk_irq(1'b1, 2'h2, SRC_EXT0);
    @(posedge clk);
    tb_clr <= 2'h1;
    @(posedge clk);
    tb_clr <= 2'h0;
    wait_n(2);
    chk_v({6'h0, flags}, 8'h00);
    @(posedge clk);
    esel <= 2'h0;
    pin <= 2'h0;
    wait_n(5);
    chk_v({6'h0, flags}, 8'h01);
    // Handler runs, timer level 0 waits behind the mask
    @(posedge clk);
    svc <= 1'b1;
    tmr <= 1'b1;
    pc <= 8'h00;
    wait_n(8);
    chk_v({6'h0, flags}, 8'h00);
    chk_v(rdata, 8'h01);
    chk_irq(1'b0, 2'h0, SRC_NONE);
    @(posedge clk);
    pc <= 8'h01;
    wait_n(2);
    chk_irq(1'b1, 2'h1, SRC_TIMER);
    @(posedge clk);
    pc <= 8'h00;
    tb_we <= 1'b1;
    tb_wd <= 8'h00;
    @(posedge clk);
    tb_we <= 1'b0;
    wait_n(2);
    chk_irq(1'b1, 2'h0, SRC_TIMER);
    // Pin 0 at level 0 loses to timer level 1, then wins the tie at level 0
    @(posedge clk);
    svc <= 1'b0;
    pa <= 8'h00;
    pc <= 8'h01;
    esel <= 2'h1;
    pin <= 2'h1;
    wait_n(5);
    chk_v({6'h0, flags}, 8'h01);
    chk_irq(1'b1, 2'h1, SRC_TIMER);
    @(posedge clk);
    pc <= 8'h00;
    wait_n(2);
    chk_irq(1'b1, 2'h0, SRC_EXT0);
    // Port mode: clears still work, pin 1 rise with its falling edge selected sets nothing
    @(posedge clk);
    fsel <= 2'h0;
    pin <= 2'h3;
    tb_clr <= 2'h1;
    @(posedge clk);
    tb_clr <= 2'h0;
    wait_n(5);
    chk_v({6'h0, flags}, 8'h00);
    chk_v({6'h0, port_in}, 8'h03);
    // Mid-run reset with pins high and the rising edge selected on pin 0
    @(posedge clk);
    nrst <= 1'b0;
    fsel <= 2'h3;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_n(1);
    chk_v(rdata, MASK_RESET);
    chk_v({6'h0, port_in}, 8'h00);
    chk_irq(1'b0, 2'h0, SRC_NONE);
    wait_n(4);
    chk_v({6'h0, flags}, 8'h00);
    chk_irq(1'b1, 2'h0, SRC_TIMER);
    complete_run();
  end
endmodule
